// *** hw/pmcd_defs.svh ***
/*
  Constants of the power and core clock control block: register byte
  addresses, key values, field positions and the reset value.
  Assumes it is included by bare name from the block's package and module.
*/
`ifndef PMCD_DEFS_SVH
`define PMCD_DEFS_SVH

// register byte addresses on the plain register port
`define PMCD_ADDR_PREWRITE_KEY 32'hffff0404
`define PMCD_ADDR_CONTROL 32'hffff0408
`define PMCD_ADDR_POSTWRITE_KEY 32'hffff040c

// key values that must surround a control write
`define PMCD_PREWRITE_KEY 32'h00000001
`define PMCD_POSTWRITE_KEY 32'h000000f4

// control register layout
`define PMCD_CTL_RESET 8'h79
`define PMCD_BIT_PREC_IN 7
`define PMCD_BIT_XTAL 6
`define PMCD_BIT_PLL 5
`define PMCD_BIT_PERIPH 4
`define PMCD_BIT_CORE 3
`define PMCD_CD_MSB 2
`define PMCD_CD_LSB 0

// divider counter width: the slowest code divides by 2**7
`define PMCD_DIV_CNT_W 7

`endif

// *** hw/pmcd_pkg.sv ***
/*
  Types of the power and core clock control block: register port carrier,
  power enable carrier and the key sequence states.
  Assumes pmcd_defs.svh sits beside it.
*/
`include "pmcd_defs.svh"

package pmcd_pkg;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic we;
    logic re;
  } pmcd_bus_req_t;

  // one bit per peripheral that the peripheral enable removes power from
  typedef struct packed {
    logic sram;
    logic prog_mem_if;
    logic gpio;
    logic spi;
    logic uart;
  } pmcd_periph_en_t;

  typedef struct packed {
    logic precision_input_en;
    logic precision_osc_run;
    logic xtal_en;
    logic pll_en;
    logic pll_timer_clk_en;
    pmcd_periph_en_t periph_en;
    logic lin_wake_detect_en;
    logic wakeup_timer_run;
    logic core_en;
  } pmcd_power_t;

  typedef enum logic [1:0] {
    PMCD_KEY_IDLE = 2'b00,
    PMCD_KEY_ARMED = 2'b01,
    PMCD_KEY_LOADED = 2'b10
  } pmcd_key_state_t;

endpackage

// *** hw/pmcd_power_clock_ctrl.sv ***
/*
  Power and core clock control register with its two protection keys,
  the power enables it drives and the core clock divider tick.
  Assumes software on the plain register port with one-cycle strobes and
  read data in the next cycle; clk stands for the PLL output rate, so the
  divider tick marks core clock edges; the wake-up input comes from
  outside the clock domain.

*/
`timescale 1ns/1ns
`include "pmcd_defs.svh"

module pmcd_power_clock_ctrl
  import pmcd_pkg::*;
#(
  parameter int DIV_CNT_W = `PMCD_DIV_CNT_W
) (
  input wire logic clk, // system clock, 100 MHz
  input wire logic reset_n, // asynchronous reset, active low
  input wire pmcd_bus_req_t bus_req, // register port request
  output logic [31:0] bus_rdata, // read data, cycle after the read strobe
  input wire logic wakeup_event, // wake-up request from outside, level
  input wire logic high_voltage_config_zero_osc, // oscillator enable from high voltage config bit 6
  input wire logic wakeup_timer_on_lp_osc, // wake-up timer clocked from low power oscillator
  output pmcd_power_t power, // power enables
  output logic [2:0] core_clock_divider, // current divider code
  output logic core_clk_tick // one-cycle pulse per core clock period
);

  logic [7:0] ctl_q;
  logic [7:0] ctl_d;
  logic [7:0] pend_q;
  logic [7:0] pend_d;
  pmcd_key_state_t key_q;
  pmcd_key_state_t key_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic wake_s1_q;
  logic wake_s2_q;
  logic [DIV_CNT_W-1:0] div_cnt_q;
  logic [DIV_CNT_W-1:0] div_cnt_d;

  // address decode
  wire logic hit_pre = bus_req.addr == `PMCD_ADDR_PREWRITE_KEY;
  wire logic hit_ctl = bus_req.addr == `PMCD_ADDR_CONTROL;
  wire logic hit_post = bus_req.addr == `PMCD_ADDR_POSTWRITE_KEY;
  wire logic wr_pre_key = bus_req.we && hit_pre && bus_req.wdata == `PMCD_PREWRITE_KEY;
  wire logic wr_ctl = bus_req.we && hit_ctl;
  wire logic wr_post_key = bus_req.we && hit_post && bus_req.wdata == `PMCD_POSTWRITE_KEY;
  wire logic commit = wr_post_key && key_q == PMCD_KEY_LOADED;

  // the pending value is corrected before it lands so that an illegal
  // partial power-down never reaches the enables, not even for a cycle
  wire logic new_core = pend_q[`PMCD_BIT_CORE];
  wire logic new_periph = pend_q[`PMCD_BIT_PERIPH] | new_core;
  wire logic new_pll = pend_q[`PMCD_BIT_PLL] | new_periph;
  wire logic [7:0] committed_val = {pend_q[7:6], new_pll, new_periph, new_core, pend_q[2:0]};

  // wake-up forces the three run bits high; it wins over a commit
  wire logic wake_set = wake_s2_q;
  wire logic [7:0] wake_mask = (8'h1 << `PMCD_BIT_PLL) | (8'h1 << `PMCD_BIT_PERIPH) | (8'h1 << `PMCD_BIT_CORE);

  // key sequence: prewrite key, control write, postwrite key; any other
  // write in between breaks it, save that a prewrite key write starts it again; reads do not
  always_comb begin
    key_d = key_q;
    pend_d = pend_q;
    if (bus_req.we) begin
      case (key_q)
        PMCD_KEY_IDLE: begin
          key_d = wr_pre_key ? PMCD_KEY_ARMED : PMCD_KEY_IDLE;
        end
        PMCD_KEY_ARMED: begin
          if (wr_ctl) begin
            key_d = PMCD_KEY_LOADED;
            pend_d = bus_req.wdata[7:0];
          end else begin
            key_d = wr_pre_key ? PMCD_KEY_ARMED : PMCD_KEY_IDLE;
          end
        end
        PMCD_KEY_LOADED: begin
          key_d = wr_pre_key ? PMCD_KEY_ARMED : PMCD_KEY_IDLE;
        end
        default: begin
          key_d = PMCD_KEY_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    ctl_d = ctl_q;
    if (commit) begin
      ctl_d = committed_val;
    end
    if (wake_set) begin
      ctl_d = ctl_d | wake_mask;
    end
  end

  // read mux: keys are write only, unmapped reads give zero
  always_comb begin
    rdata_d = 32'h0;
    if (bus_req.re && hit_ctl) begin
      rdata_d = {24'h0, ctl_q};
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wake_s1_q <= 1'b0;
      wake_s2_q <= 1'b0;
    end else begin
      wake_s1_q <= wakeup_event;
      wake_s2_q <= wake_s1_q;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      key_q <= PMCD_KEY_IDLE;
      pend_q <= 8'h0;
      ctl_q <= `PMCD_CTL_RESET;
      rdata_q <= 32'h0;
    end else begin
      key_q <= key_d;
      pend_q <= pend_d;
      ctl_q <= ctl_d;
      rdata_q <= rdata_d;
    end
  end

  assign bus_rdata = rdata_q;

  // power enables
  assign power.precision_input_en = ctl_q[`PMCD_BIT_PREC_IN];
  assign power.precision_osc_run = ctl_q[`PMCD_BIT_PREC_IN] & high_voltage_config_zero_osc;
  assign power.xtal_en = ctl_q[`PMCD_BIT_XTAL];
  assign power.pll_en = ctl_q[`PMCD_BIT_PLL];
  assign power.pll_timer_clk_en = ctl_q[`PMCD_BIT_PLL];
  // one gate per peripheral; all follow the same bit, but the carrier
  // keeps them apart so a later split touches only this loop
  localparam int PERIPH_N = $bits(pmcd_periph_en_t);
  logic [PERIPH_N-1:0] periph_bits;
  for (genvar g = 0; g < PERIPH_N; g++) begin : g_periph
    assign periph_bits[g] = ctl_q[`PMCD_BIT_PERIPH];
  end
  assign power.periph_en = periph_bits;
  // LIN wake detection never depends on the peripheral bit; the wake-up timer needs it unless it runs from the low power oscillator
  assign power.lin_wake_detect_en = 1'b1;
  assign power.wakeup_timer_run = ctl_q[`PMCD_BIT_PERIPH] | wakeup_timer_on_lp_osc;
  assign power.core_en = ctl_q[`PMCD_BIT_CORE];

  // core clock divider: code n gives one tick every 2**n cycles; the
  // counter runs only with the PLL up, since it stands for the PLL output
  wire logic [DIV_CNT_W-1:0] div_mask = DIV_CNT_W'((1 << ctl_q[`PMCD_CD_MSB:`PMCD_CD_LSB]) - 1);
  wire logic div_wrap = (div_cnt_q & div_mask) == div_mask;

  assign core_clock_divider = ctl_q[`PMCD_CD_MSB:`PMCD_CD_LSB];

  always_comb begin
    div_cnt_d = div_cnt_q;
    if (!ctl_q[`PMCD_BIT_PLL]) begin
      div_cnt_d = '0;
    end else if (div_wrap) begin
      div_cnt_d = '0;
    end else begin
      div_cnt_d = div_cnt_q + DIV_CNT_W'(1);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      div_cnt_q <= '0;
    end else begin
      div_cnt_q <= div_cnt_d;
    end
  end

  // no core clock while the core is stopped
  assign core_clk_tick = div_wrap & ctl_q[`PMCD_BIT_PLL] & ctl_q[`PMCD_BIT_CORE];

  // checker helper: cycles since the last tick, trusted only while the
  // control byte has not moved since that tick, because a code change
  // leaves one irregular period behind it
  logic [DIV_CNT_W:0] gap_q;
  logic [DIV_CNT_W:0] gap_d;
  logic gap_valid_q;
  logic gap_valid_d;
  wire logic [DIV_CNT_W:0] gap_one = {{DIV_CNT_W{1'b0}}, 1'b1};
  wire logic [DIV_CNT_W:0] gap_expect = gap_one << ctl_q[`PMCD_CD_MSB:`PMCD_CD_LSB];

  always_comb begin
    gap_d = gap_q;
    gap_valid_d = gap_valid_q;
    if (core_clk_tick) begin
      gap_d = gap_one;
      gap_valid_d = 1'b1;
    end else if (gap_q != '1) begin
      gap_d = gap_q + gap_one;
    end
    if (ctl_d != ctl_q) begin
      gap_valid_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      gap_q <= '0;
      gap_valid_q <= 1'b0;
    end else begin
      gap_q <= gap_d;
      gap_valid_q <= gap_valid_d;
    end
  end

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  sequence s_pre;
    bus_req.we && hit_pre && bus_req.wdata == `PMCD_PREWRITE_KEY;
  endsequence

  sequence s_ctl;
    bus_req.we && hit_ctl;
  endsequence

  sequence s_post;
    bus_req.we && hit_post && bus_req.wdata == `PMCD_POSTWRITE_KEY;
  endsequence

  sequence s_keyed_write;
    s_pre ##1 s_ctl ##1 s_post;
  endsequence

  sequence s_stray;
    bus_req.we && !hit_ctl && !hit_pre;
  endsequence

  sequence s_clean_commit;
    commit && !wake_set;
  endsequence

  // a back to back keyed write lands its divider and upper bits
  AST_KEYED_WRITE_LANDS: assert property (
    (s_keyed_write ##0 !wake_set) |=> ctl_q[2:0] == $past(bus_req.wdata[2:0], 2)
      && ctl_q[7:6] == $past(bus_req.wdata[7:6], 2))
    else $error("keyed control write did not land");

  // a control write without the prewrite key changes nothing
  AST_UNKEYED_WRITE_IGNORED: assert property (
    (s_ctl ##0 (key_q == PMCD_KEY_IDLE && !wake_set)) |=> $stable(ctl_q) && key_q == PMCD_KEY_IDLE)
    else $error("unkeyed control write changed the register");

  AST_PLL_NEEDS_ALL_CLEAR: assert property (
    (commit && !wake_set && (pend_q[`PMCD_BIT_CORE] || pend_q[`PMCD_BIT_PERIPH]))
      |=> power.pll_en)
    else $error("pll powered down while core or peripherals stay on");

  AST_PERIPH_NEEDS_CORE_CLEAR: assert property (
    power.core_en |-> power.periph_en == 5'h1f && power.pll_en)
    else $error("peripherals off while core on");

  AST_WAKE_SETS_RUN_BITS: assert property (
    $rose(wakeup_event) ##1 wakeup_event ##1 wakeup_event
      |=> power.core_en && power.periph_en == 5'h1f && power.pll_en)
    else $error("wake-up did not restore the run bits");

  AST_PREC_OSC_GATED: assert property (
    power.precision_osc_run == (ctl_q[7] && high_voltage_config_zero_osc))
    else $error("precision oscillator enable wrong");

  AST_XTAL_FOLLOWS_BIT: assert property (
    power.xtal_en == ctl_q[6])
    else $error("crystal enable does not follow its bit");

  AST_PLL_TIMERS_STOP: assert property (
    !power.pll_en |-> !power.pll_timer_clk_en && !core_clk_tick)
    else $error("pll timers or core clock run with pll down");

  AST_LIN_WAKE_ALIVE: assert property (
    !power.periph_en.uart |-> power.lin_wake_detect_en
      && (power.wakeup_timer_run == wakeup_timer_on_lp_osc))
    else $error("wake detection lost with peripherals down");

  AST_CORE_STOP_NO_TICK: assert property (
    !power.core_en |-> !core_clk_tick)
    else $error("core clock ticks while core stopped");

  // slowest code: ticks exactly 128 cycles apart
  AST_DIV_SLOWEST: assert property (
    (core_clk_tick && core_clock_divider == 3'h7 && power.core_en) ##1
      ($stable(ctl_q) && !core_clk_tick) [*8] |-> ##120 (core_clk_tick || !$stable(ctl_q)))
    else $error("divide by 128 period wrong");

  AST_DIV_FASTEST: assert property (
    (core_clock_divider == 3'h0 && power.pll_en && power.core_en) |-> core_clk_tick)
    else $error("undivided core clock does not tick every cycle");

  AST_RESERVED_READ_ZERO: assert property (
    bus_req.re |=> bus_rdata[31:8] == 24'h0)
    else $error("reserved bits read non-zero");

  AST_READ_ONE_CYCLE: assert property (
    (bus_req.re && hit_ctl) |=> bus_rdata[7:0] == $past(ctl_q))
    else $error("control read data wrong");

  // any write away from the control and prewrite key addresses disarms the sequence
  AST_STRAY_WRITE_DISARMS: assert property (
    (s_pre ##1 s_stray) |=> key_q == PMCD_KEY_IDLE)
    else $error("stray write left the key sequence armed");

  AST_COMMIT_CORE_BIT: assert property (
    s_clean_commit |=> power.core_en == $past(pend_q[`PMCD_BIT_CORE]))
    else $error("core enable does not follow the committed bit");

  AST_COMMIT_PERIPH_BIT: assert property (
    s_clean_commit |=> power.periph_en.sram
      == ($past(pend_q[`PMCD_BIT_PERIPH]) || $past(pend_q[`PMCD_BIT_CORE])))
    else $error("peripheral enable does not follow the committed bits");

  AST_RDATA_IDLE_ZERO: assert property (
    !bus_req.re |=> bus_rdata == 32'h0)
    else $error("read data stands longer than one cycle");

  AST_KEYS_READ_ZERO: assert property (
    (bus_req.re && (hit_pre || hit_post)) |=> bus_rdata == 32'h0)
    else $error("key register read back non-zero");

  // every code, measured between two ticks with the control byte at rest
  AST_TICK_PERIOD: assert property (
    (core_clk_tick && gap_valid_q) |-> gap_q == gap_expect)
    else $error("core clock tick period does not match the divider code");

endmodule

// *** testbench/pmcd_power_clock_ctrl_tb.sv ***
/*
  Self-checking bench for the power and core clock control block.
  Assumes a single 100 MHz clock and software-style access on the plain register port.
*/
`timescale 1ns/1ns
`include "pmcd_defs.svh"

module pmcd_power_clock_ctrl_tb import pmcd_pkg::*; ;
  logic clk;
  logic reset_n;
  logic wakeup_event;
  logic hv_osc;
  logic lp_osc;
  logic core_clk_tick;
  logic re_seen;
  pmcd_bus_req_t bus_req;
  logic [31:0] bus_rdata;
  pmcd_power_t power;
  logic [2:0] core_clock_divider;
  logic [31:0] exp_q[$];
  logic [7:0] tbl [6];
  int bad_count;
  int check_count;
  int seed;

  pmcd_power_clock_ctrl dut (
    .clk(clk),
    .reset_n(reset_n),
    .bus_req(bus_req),
    .bus_rdata(bus_rdata),
    .wakeup_event(wakeup_event),
    .high_voltage_config_zero_osc(hv_osc),
    .wakeup_timer_on_lp_osc(lp_osc),
    .power(power),
    .core_clock_divider(core_clock_divider),
    .core_clk_tick(core_clk_tick)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, seen);
      bad_count++;
    end
  endtask

  task automatic report_and_stop();
    if (bad_count == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic req(input logic [31:0] a, input logic [31:0] d, input logic w);
    bus_req <= '{addr: a, wdata: d, we: w, re: !w};
    @(posedge clk);
  endtask

  task automatic idle();
    bus_req.we <= 1'b0;
    bus_req.re <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    req(a, 32'h0, 1'b0);
  endtask

  // upper write bits and the two side inputs are random, only the low byte counts
  task automatic keyed(input logic [7:0] d);
    logic [31:0] junk;
    junk = $random(seed);
    hv_osc <= junk[0];
    lp_osc <= junk[1];
    req(`PMCD_ADDR_PREWRITE_KEY, `PMCD_PREWRITE_KEY, 1'b1);
    req(`PMCD_ADDR_CONTROL, {junk[31:8], d}, 1'b1);
    req(`PMCD_ADDR_POSTWRITE_KEY, `PMCD_POSTWRITE_KEY, 1'b1);
    idle();
  endtask

  function automatic logic [7:0] corr(input logic [7:0] d);
    return {d[7:6], d[5] | d[4] | d[3], d[4] | d[3], d[3], d[2:0]};
  endfunction

  task automatic check_power(input logic [7:0] c);
    chk("precision_input_en", power.precision_input_en, c[7]);
    chk("precision_osc_run", power.precision_osc_run, c[7] & hv_osc);
    chk("xtal_en", power.xtal_en, c[6]);
    chk("pll_en", {power.pll_en, power.pll_timer_clk_en}, {2{c[5]}});
    chk("periph_en", power.periph_en, {5{c[4]}});
    chk("lin_wake_detect_en", power.lin_wake_detect_en, 1'b1);
    chk("wakeup_timer_run", power.wakeup_timer_run, c[4] | lp_osc);
    chk("core_en", power.core_en, c[3]);
    chk("core_clock_divider", core_clock_divider, c[2:0]);
  endtask

  // sampled at the edge: the tick seen there belongs to the cycle just ended
  task automatic tick_period(input int n);
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (core_clk_tick !== 1'b1 && k < 300);
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (core_clk_tick !== 1'b1 && k < 300);
    chk("tick_period", k, n);
    if (k >= 300) begin
      report_and_stop();
    end
  endtask

  always @(posedge clk) begin
    if (re_seen === 1'b1) begin
      if (exp_q.size() == 0) begin
        bad_count++;
        $display("Error bus_rdata expected none seen %h", bus_rdata);
      end else begin
        chk("bus_rdata", bus_rdata, exp_q.pop_front());
      end
    end
    re_seen = bus_req.re;
  end

  initial begin
    seed = 32'h330e1485;
    tbl = '{8'h28, 8'h30, 8'h10, 8'h08, 8'hc0, 8'h00};
    reset_n = 1'b0;
    wakeup_event = 1'b0;
    hv_osc = 1'b0;
    lp_osc = 1'b0;
    re_seen = 1'b0;
    bus_req = '0;
    bad_count = 0;
    check_count = 0;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    check_power(8'h79);
    rd(`PMCD_ADDR_CONTROL, 32'h79);
    rd(`PMCD_ADDR_PREWRITE_KEY, 32'h0);
    rd(32'hffff0500, 32'h0);
    // a bare write, and a keyed one broken by a stray write, must both be dropped
    req(`PMCD_ADDR_CONTROL, 32'hff, 1'b1);
    req(`PMCD_ADDR_PREWRITE_KEY, `PMCD_PREWRITE_KEY, 1'b1);
    req(32'hffff0500, 32'h5, 1'b1);
    req(`PMCD_ADDR_CONTROL, 32'h00, 1'b1);
    req(`PMCD_ADDR_POSTWRITE_KEY, `PMCD_POSTWRITE_KEY, 1'b1);
    rd(`PMCD_ADDR_CONTROL, 32'h79);
    idle();
    for (int i = 0; i < 8; i++) begin
      keyed({5'b11111, 3'(i)});
      check_power({5'b11111, 3'(i)});
      tick_period(1 << i);
    end
    for (int i = 0; i < 6; i++) begin
      keyed(tbl[i]);
      check_power(corr(tbl[i]));
      rd(`PMCD_ADDR_CONTROL, {24'h0, corr(tbl[i])});
      idle();
    end
    wakeup_event <= 1'b1;
    repeat (4) @(posedge clk);
    check_power(8'h38);
    wakeup_event <= 1'b0;
    repeat (4) @(posedge clk);
    check_power(8'h38);
    rd(`PMCD_ADDR_CONTROL, 32'h38);
    idle();
    // a reset in mid-run brings the power-on value back at once
    reset_n <= 1'b0;
    @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    check_power(8'h79);
    rd(`PMCD_ADDR_CONTROL, 32'h79);
    idle();
    repeat (3) @(posedge clk);
    chk("read_queue_left", exp_q.size(), 32'h0);
    report_and_stop();
  end
endmodule
